// ==== ldrmp_pkg.sv ====
// package: register map, field layouts and timing for the led driver block
package ldrmp_pkg;

  // ----------------------------------------------------------------
  // register offsets (register pointer values)
  // ----------------------------------------------------------------
  localparam logic [3:0] OFF_MODE_CTRL_FIRST = 4'h0;
  localparam logic [3:0] OFF_MODE_CTRL_SECOND = 4'h1;
  localparam logic [3:0] OFF_DUTY0 = 4'h2;
  localparam logic [3:0] OFF_DUTY3 = 4'h5;
  localparam logic [3:0] OFF_GDUTY = 4'h6;
  localparam logic [3:0] OFF_GPER = 4'h7;
  localparam logic [3:0] OFF_LEDSEL = 4'h8;
  localparam logic [3:0] OFF_ALIAS1 = 4'h9;
  localparam logic [3:0] OFF_ALIAS2 = 4'hA;
  localparam logic [3:0] OFF_ALIAS3 = 4'hB;
  localparam logic [3:0] OFF_BCAST = 4'hC;
  localparam logic [3:0] OFF_LAST = 4'hC;

  // ----------------------------------------------------------------
  // control byte fields
  // ----------------------------------------------------------------
  localparam int CTRL_PTR_LSB = 0;
  localparam int CTRL_INCR_LSB = 5;
  localparam logic [2:0] INCR_RST = 3'h4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_CTRL_FIRST_RST = 8'h91;
  localparam logic [7:0] MODE_CTRL_SECOND_RST = 8'h01;
  localparam logic [7:0] DUTY_RST = 8'h00;
  localparam logic [7:0] GDUTY_RST = 8'hFF;
  localparam logic [7:0] GPER_RST = 8'h00;
  localparam logic [7:0] LEDSEL_RST = 8'h00;
  localparam logic [7:0] ALIAS1_RST = 8'hE2;
  localparam logic [7:0] ALIAS2_RST = 8'hE4;
  localparam logic [7:0] ALIAS3_RST = 8'hE8;
  localparam logic [7:0] BCAST_RST = 8'hE0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 10_000_000;
  localparam longint IND_PWM_MILLIHZ = 1_562_500;
  localparam longint PWM_STEPS = 256;
  localparam int TICK_CYCLES =
    int'((CLK_HZ * 1000) / (IND_PWM_MILLIHZ * PWM_STEPS));
  localparam longint GRP_DIM_HZ = 190;
  localparam int GRP_DIM_STEP_CYCLES =
    int'(CLK_HZ / (GRP_DIM_HZ * PWM_STEPS));
  localparam longint BLINK_DIVISOR = 24;
  localparam int BLINK_STEP_CYCLES =
    int'(CLK_HZ / (BLINK_DIVISOR * PWM_STEPS));
  localparam logic [7:0] BLINK_FAST_MAX = 8'h03;
  localparam longint WAKE_US = 500;
  localparam int WAKE_CYCLES = int'((CLK_HZ / 1_000_000) * WAKE_US);

  // ----------------------------------------------------------------
  // channel output select codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_OFF = 2'h0;
  localparam logic [1:0] SEL_ON = 2'h1;
  localparam logic [1:0] SEL_IND = 2'h2;
  localparam logic [1:0] SEL_GRP = 2'h3;

  // ----------------------------------------------------------------
  // packed register layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic incr_flag;
    logic incr_option_hi;
    logic incr_option_lo;
    logic sleep;
    logic alias_one_enable;
    logic alias_two_enable;
    logic alias_three_enable;
    logic broadcast_enable;
  } ldrmp_mode_ctrl_first_t;

  typedef struct packed {
    logic [1:0] reserved;
    logic group_blink_select;
    logic output_invert;
    logic update_on_ack;
    logic push_pull_select;
    logic [1:0] spare_output_field;
  } ldrmp_mode_ctrl_second_t;

  typedef struct packed {
    logic alias_one_enable;
    logic alias_two_enable;
    logic alias_three_enable;
    logic broadcast_enable;
    logic [6:0] alias_one;
    logic [6:0] alias_two;
    logic [6:0] alias_three;
    logic [6:0] broadcast;
  } ldrmp_alias_t;

endpackage

// ==== ldrmp_timebase.sv ====
// module: oscillator wake-up, pwm step counter and group gate
module ldrmp_timebase
  import ldrmp_pkg::*;
#(
  parameter int WAKE = WAKE_CYCLES
) (
  input wire logic clk, // clock
  input wire logic rst, // synchronous reset
  input wire logic sleep, // low power request
  input wire logic blink_sel, // group blink instead of dim
  input wire logic [7:0] gduty, // applied group duty
  input wire logic [7:0] gper, // applied group period
  output logic run_q, // oscillator running
  output logic [7:0] step_q, // individual pwm counter
  output logic gate_q // group gate
);
  // ----------------------------------------------------------------
  // oscillator
  // ----------------------------------------------------------------
  logic [12:0] wake_q;
  logic [4:0] tick_q;
  logic tick;
  logic [7:0] gstep_q;
  logic [10:0] gpre_q;
  logic [7:0] gsub_q;
  logic gadv;
  logic [7:0] gdty;

  always_ff @(posedge clk) begin
    if (rst || sleep) begin
      wake_q <= 13'h0000;
      run_q <= 1'b0;
    end else if (!run_q) begin
      if (wake_q >= 13'(WAKE - 1)) begin
        run_q <= 1'b1;
      end
      wake_q <= wake_q + 13'h0001;
    end
  end

  // ----------------------------------------------------------------
  // individual pwm: one step per tick, 256 steps per period
  // ----------------------------------------------------------------
  assign tick = run_q && (tick_q == 5'(TICK_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (rst || !run_q) begin
      tick_q <= 5'h00;
    end else begin
      tick_q <= tick ? 5'h00 : tick_q + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      step_q <= 8'h00;
    end else if (tick) begin
      step_q <= step_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // group dimming and blinking
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || !run_q) begin
      gpre_q <= 11'h000;
      gsub_q <= 8'h00;
      gstep_q <= gstep_q;
      if (rst) begin
        gstep_q <= 8'h00;
      end
    end else if (!blink_sel) begin
      gsub_q <= 8'h00;
      if (gpre_q >= 11'(GRP_DIM_STEP_CYCLES - 1)) begin
        gpre_q <= 11'h000;
        gstep_q <= gstep_q + 8'h01;
      end else begin
        gpre_q <= gpre_q + 11'h001;
      end
    end else if (gpre_q >= 11'(BLINK_STEP_CYCLES - 1)) begin
      gpre_q <= 11'h000;
      if (gadv) begin
        gsub_q <= 8'h00;
        gstep_q <= gstep_q + 8'h01;
      end else begin
        gsub_q <= gsub_q + 8'h01;
      end
    end else begin
      gpre_q <= gpre_q + 11'h001;
    end
  end

  assign gadv = (gsub_q >= gper);

  always_comb begin
    if (!blink_sel) begin
      gdty = {gduty[7:4], 4'h0};
    end else if (gper <= BLINK_FAST_MAX) begin
      gdty = {gduty[7:2], 2'h0};
    end else begin
      gdty = gduty;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      gate_q <= 1'b0;
    end else if (run_q) begin
      gate_q <= (gstep_q < gdty);
    end
  end
endmodule

// ==== ldrmp_channel.sv ====
// module: per-channel on/off decision from select, duty and group gate
module ldrmp_channel
  import ldrmp_pkg::*;
(
  input wire logic [1:0] sel, // channel output select
  input wire logic [7:0] duty, // channel duty value
  input wire logic blink_sel, // group blink instead of dim
  input wire logic [7:0] step, // individual pwm counter
  input wire logic gate, // group gate
  output logic on // channel active
);
  logic ind8;
  logic ind6;

  assign ind8 = (step < duty);
  assign ind6 = (step[5:0] < duty[7:2]);

  always_comb begin
    case (sel)
      SEL_OFF: on = 1'b0;
      SEL_ON: on = 1'b1;
      SEL_IND: on = ind8;
      default: on = gate && (blink_sel ? ind8 : ind6);
    endcase
  end
endmodule

// ==== ldrmp_top.sv ====
// top: register map, update timing and four led channel outputs
// Overview of operation
// - pointer 0000..1100 acknowledged; 1101..1111 refused without acknowledge.
// - first mode bits 7..5 read-only increment flag/options; reset 1,0,0.
// - first mode bit 4: 1 low power oscillator stopped (reset), 0 normal.
// - oscillator runs within 500 us after low power cleared.
// - oscillator stopped: outputs never switch, dim or blink.
// - first mode bits 3..1 enable alias addresses one..three; reset 0.
// - first mode bit 0 enables broadcast address; reset 1.
// - second mode bit 5: 0 group dimming (reset), 1 blinking.
// - second mode bit 4 inverts all led outputs; reset uninverted.
// - second mode bit 3: 0 apply at STOP (reset), 1 at acknowledge.
// - update timing applies only to offsets 02h..08h.
// - second mode bit 2: 0 open-drain (reset), 1 totem pole.
// - individual mode: 1.5625 kHz pwm, duty value/256, 00h off.
// - group dimming: 6.25 kHz, 64 steps, duty bits 7..2 only.
// - blink mode: 1.5625 kHz pwm, full 8-bit duty out of 256.
// - select field: 00 off, 01 on, 10 pwm, 11 pwm plus group.
// - group dimming superimposes 190 Hz group pwm on channel pwm.
// - blink period is (group period + 1) / 24 seconds.
module ldrmp_top
  import ldrmp_pkg::*;
#(
  parameter int WAKE = WAKE_CYCLES,
  parameter int CHANNELS = 4
) (
  input wire logic clk, // clock, 10 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic ctrl_load, // control byte strobe
  input wire logic [7:0] ctrl_byte, // control byte
  input wire logic wr_stb, // data write strobe
  input wire logic [7:0] wr_data, // data byte to write
  input wire logic rd_stb, // data read strobe
  input wire logic stop_stb, // bus stop condition
  output logic ptr_ack_q, // pointer accepted
  output logic ptr_nack_q, // pointer refused
  output logic data_ack_q, // write acknowledged
  output logic rd_valid_q, // read data valid
  output logic [7:0] rd_data_q, // read data
  output ldrmp_pkg::ldrmp_alias_t alias_q, // address match settings
  output logic [CHANNELS-1:0] led_o_q, // led pin level
  output logic [CHANNELS-1:0] led_oe_q // led pin drive enable
);
  import ldrmp_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [2:0] incr_q;
  logic [3:0] ptr_q;
  logic sleep_q;
  logic [3:0] alias_en_q;
  ldrmp_mode_ctrl_first_t mode_ctrl_first;
  ldrmp_mode_ctrl_second_t mode_ctrl_second_q;
  logic [7:0] duty_stage_q [CHANNELS];
  logic [7:0] duty_act_q [CHANNELS];
  logic [7:0] gduty_stage_q;
  logic [7:0] gduty_act_q;
  logic [7:0] gper_stage_q;
  logic [7:0] gper_act_q;
  logic [7:0] ledsel_stage_q;
  logic [7:0] ledsel_act_q;
  logic [6:0] alias1_q;
  logic [6:0] alias2_q;
  logic [6:0] alias3_q;
  logic [6:0] bcast_q;
  logic apply_q;
  logic wr_shadow;
  logic ptr_ok;
  logic run;
  logic [7:0] step;
  logic gate;
  logic [CHANNELS-1:0] on;
  logic [7:0] rd_d;

  // ----------------------------------------------------------------
  // register pointer
  // ----------------------------------------------------------------
  assign ptr_ok = (ctrl_byte[CTRL_PTR_LSB +: 4] <= OFF_LAST);

  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_q <= OFF_MODE_CTRL_FIRST;
      incr_q <= INCR_RST;
    end else if (ctrl_load && ptr_ok) begin
      // bit 4 is unused and never decoded
      ptr_q <= ctrl_byte[CTRL_PTR_LSB +: 4];
      incr_q <= ctrl_byte[CTRL_INCR_LSB +: 3];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_ack_q <= 1'b0;
      ptr_nack_q <= 1'b0;
    end else begin
      ptr_ack_q <= ctrl_load && ptr_ok;
      ptr_nack_q <= ctrl_load && !ptr_ok;
    end
  end

  // ----------------------------------------------------------------
  // mode registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      sleep_q <= MODE_CTRL_FIRST_RST[4];
      alias_en_q <= MODE_CTRL_FIRST_RST[3:0];
    end else if (wr_stb && ptr_q == OFF_MODE_CTRL_FIRST) begin
      sleep_q <= wr_data[4];
      alias_en_q <= wr_data[3:0];
    end
  end

  assign mode_ctrl_first = {incr_q, sleep_q, alias_en_q};

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_ctrl_second_q <= MODE_CTRL_SECOND_RST;
    end else if (wr_stb && ptr_q == OFF_MODE_CTRL_SECOND) begin
      mode_ctrl_second_q <= {2'h0, wr_data[5:0]};
    end
  end

  // ----------------------------------------------------------------
  // staged output registers, 02h..08h
  // ----------------------------------------------------------------
  assign wr_shadow = wr_stb && ptr_q >= OFF_DUTY0 && ptr_q <= OFF_LEDSEL;

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_duty
      always_ff @(posedge clk) begin
        if (rst) begin
          duty_stage_q[g] <= DUTY_RST;
        end else if (wr_stb && ptr_q == OFF_DUTY0 + 4'(g)) begin
          duty_stage_q[g] <= wr_data;
        end
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          duty_act_q[g] <= DUTY_RST;
        end else if (apply_q || stop_stb) begin
          duty_act_q[g] <= duty_stage_q[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      gduty_stage_q <= GDUTY_RST;
      gper_stage_q <= GPER_RST;
      ledsel_stage_q <= LEDSEL_RST;
    end else if (wr_stb && ptr_q == OFF_GDUTY) begin
      gduty_stage_q <= wr_data;
    end else if (wr_stb && ptr_q == OFF_GPER) begin
      gper_stage_q <= wr_data;
    end else if (wr_stb && ptr_q == OFF_LEDSEL) begin
      ledsel_stage_q <= wr_data;
    end
  end

  // ack mode applies one cycle after the data write, stop mode at stop
  always_ff @(posedge clk) begin
    if (rst) begin
      apply_q <= 1'b0;
    end else begin
      apply_q <= wr_shadow && mode_ctrl_second_q.update_on_ack;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      gduty_act_q <= GDUTY_RST;
      gper_act_q <= GPER_RST;
      ledsel_act_q <= LEDSEL_RST;
    end else if (apply_q || stop_stb) begin
      gduty_act_q <= gduty_stage_q;
      gper_act_q <= gper_stage_q;
      ledsel_act_q <= ledsel_stage_q;
    end
  end

  // ----------------------------------------------------------------
  // alias address registers, applied at once
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      alias1_q <= ALIAS1_RST[7:1];
      alias2_q <= ALIAS2_RST[7:1];
      alias3_q <= ALIAS3_RST[7:1];
      bcast_q <= BCAST_RST[7:1];
    end else if (wr_stb && ptr_q == OFF_ALIAS1) begin
      alias1_q <= wr_data[7:1];
    end else if (wr_stb && ptr_q == OFF_ALIAS2) begin
      alias2_q <= wr_data[7:1];
    end else if (wr_stb && ptr_q == OFF_ALIAS3) begin
      alias3_q <= wr_data[7:1];
    end else if (wr_stb && ptr_q == OFF_BCAST) begin
      bcast_q <= wr_data[7:1];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      alias_q <= {MODE_CTRL_FIRST_RST[3:0], ALIAS1_RST[7:1], ALIAS2_RST[7:1],
                  ALIAS3_RST[7:1], BCAST_RST[7:1]};
    end else begin
      alias_q <= {alias_en_q, alias1_q, alias2_q, alias3_q, bcast_q};
    end
  end

  // ----------------------------------------------------------------
  // read path and write acknowledge
  // ----------------------------------------------------------------
  always_comb begin
    if (ptr_q == OFF_MODE_CTRL_FIRST) begin
      rd_d = mode_ctrl_first;
    end else if (ptr_q == OFF_MODE_CTRL_SECOND) begin
      rd_d = mode_ctrl_second_q;
    end else if (ptr_q >= OFF_DUTY0 && ptr_q <= OFF_DUTY3) begin
      rd_d = duty_stage_q[2'(ptr_q - OFF_DUTY0)];
    end else if (ptr_q == OFF_GDUTY) begin
      rd_d = gduty_stage_q;
    end else if (ptr_q == OFF_GPER) begin
      rd_d = gper_stage_q;
    end else if (ptr_q == OFF_LEDSEL) begin
      rd_d = ledsel_stage_q;
    end else if (ptr_q == OFF_ALIAS1) begin
      rd_d = {alias1_q, 1'b0};
    end else if (ptr_q == OFF_ALIAS2) begin
      rd_d = {alias2_q, 1'b0};
    end else if (ptr_q == OFF_ALIAS3) begin
      rd_d = {alias3_q, 1'b0};
    end else if (ptr_q == OFF_BCAST) begin
      rd_d = {bcast_q, 1'b0};
    end else begin
      rd_d = 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_valid_q <= 1'b0;
      rd_data_q <= 8'h00;
      data_ack_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_stb;
      data_ack_q <= wr_stb;
      if (rd_stb) begin
        rd_data_q <= rd_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // timebase and channels
  // ----------------------------------------------------------------
  ldrmp_timebase #(
    .WAKE(WAKE)
  ) u_timebase (
    .clk(clk),
    .rst(rst),
    .sleep(sleep_q),
    .blink_sel(mode_ctrl_second_q.group_blink_select),
    .gduty(gduty_act_q),
    .gper(gper_act_q),
    .run_q(run),
    .step_q(step),
    .gate_q(gate)
  );

  generate
    for (g = 0; g < CHANNELS; g++) begin : g_chan
      ldrmp_channel u_channel (
        .sel(ledsel_act_q[2*g +: 2]),
        .duty(duty_act_q[g]),
        .blink_sel(mode_ctrl_second_q.group_blink_select),
        .step(step),
        .gate(gate),
        .on(on[g])
      );

      // led sinks current when on unless output_invert is set; outputs frozen while stopped
      always_ff @(posedge clk) begin
        if (rst) begin
          led_o_q[g] <= 1'b1;
          led_oe_q[g] <= 1'b0;
        end else if (run) begin
          led_o_q[g] <= ~on[g] ^ mode_ctrl_second_q.output_invert;
          led_oe_q[g] <= mode_ctrl_second_q.push_pull_select |
                         ~(~on[g] ^ mode_ctrl_second_q.output_invert);
        end
      end
    end
  endgenerate
endmodule

// ==== ldrmp_asserts.sv ====
// checker: port-level properties of the led driver register block
module ldrmp_asserts
  import ldrmp_pkg::*;
#(
  parameter int CHANNELS = 4
) (
  input wire logic clk, // clock
  input wire logic rst, // synchronous reset
  input wire logic ctrl_load, // control byte strobe
  input wire logic [7:0] ctrl_byte, // control byte
  input wire logic wr_stb, // write strobe
  input wire logic [7:0] wr_data, // write data
  input wire logic rd_stb, // read strobe
  input wire logic stop_stb, // stop condition
  input wire logic ptr_ack_q, // pointer accepted
  input wire logic ptr_nack_q, // pointer refused
  input wire logic data_ack_q, // write acknowledged
  input wire logic rd_valid_q, // read valid
  input wire logic [7:0] rd_data_q, // read data
  input wire ldrmp_pkg::ldrmp_alias_t alias_q, // address settings
  input wire logic [CHANNELS-1:0] led_o_q, // pin level
  input wire logic [CHANNELS-1:0] led_oe_q // pin enable
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  ptr_ack_a: assert property (
    ctrl_load && ctrl_byte[3:0] <= OFF_LAST |=> ptr_ack_q && !ptr_nack_q)
    else $error("valid pointer not acknowledged");
  ptr_nack_a: assert property (
    ctrl_load && ctrl_byte[3:0] > OFF_LAST |=> ptr_nack_q && !ptr_ack_q)
    else $error("reserved pointer not refused");
  ptr_quiet_a: assert property (
    !ctrl_load |=> !ptr_ack_q && !ptr_nack_q)
    else $error("pointer answer without request");
  wr_ack_a: assert property (wr_stb |=>
    data_ack_q ##1 data_ack_q == $past(wr_stb))
    else $error("write acknowledge missing or stuck");
  wr_quiet_a: assert property (!wr_stb |=> !data_ack_q)
    else $error("write acknowledge without write");
  rd_valid_a: assert property (rd_stb |=> rd_valid_q)
    else $error("read valid missing");
  rd_hold_a: assert property (!rd_stb |=> !rd_valid_q && $stable(rd_data_q))
    else $error("read data changed without read");
  alias_hold_a: assert property (!wr_stb |=> ##1 $stable(alias_q))
    else $error("address settings changed without write");
  sink_drive_a: assert property ((~led_o_q & ~led_oe_q) == '0)
    else $error("low pin level not driven");

  cover property (ptr_nack_q);
  cover property (rd_valid_q);
  cover property (&led_oe_q);
endmodule

bind ldrmp_top ldrmp_asserts #(.CHANNELS(CHANNELS)) ldrmp_asserts_inst (
  .clk(clk), .rst(rst), .ctrl_load(ctrl_load), .ctrl_byte(ctrl_byte),
  .wr_stb(wr_stb), .wr_data(wr_data), .rd_stb(rd_stb),
  .stop_stb(stop_stb), .ptr_ack_q(ptr_ack_q), .ptr_nack_q(ptr_nack_q),
  .data_ack_q(data_ack_q), .rd_valid_q(rd_valid_q),
  .rd_data_q(rd_data_q), .alias_q(alias_q), .led_o_q(led_o_q),
  .led_oe_q(led_oe_q));

// ==== ldrmp_master.sv ====
// partner: bus master model issuing control, write, read and stop
module ldrmp_master (
  input wire logic clk, // clock
  output logic ctrl_load, // control strobe
  output logic [7:0] ctrl_byte, // control byte
  output logic wr_stb, // write strobe
  output logic [7:0] wr_data, // write data
  output logic rd_stb, // read strobe
  output logic stop_stb // stop condition
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {ctrl_load, wr_stb, rd_stb, stop_stb} = 4'h0;
    ctrl_byte = 8'h00;
    wr_data = 8'h00;
  end
  task automatic ptr(input logic [3:0] p);
    @(posedge clk);
    ctrl_load <= 1'b1;
    ctrl_byte <= {3'h4, 1'b0, p};
    @(posedge clk);
    ctrl_load <= 1'b0;
    ctrl_byte <= ~{3'h4, 1'b0, p};
  endtask
  task automatic wr(input logic [7:0] d);
    @(posedge clk);
    wr_stb <= 1'b1;
    wr_data <= d;
    @(posedge clk);
    wr_stb <= 1'b0;
    wr_data <= ~d;
  endtask
  task automatic rd();
    @(posedge clk);
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
  endtask
  task automatic stop();
    @(posedge clk);
    stop_stb <= 1'b1;
    @(posedge clk);
    stop_stb <= 1'b0;
  endtask
endmodule

// ==== ldrmp_top_test.sv ====
// testbench: register map, update timing and led pwm of the driver
module ldrmp_top_test;
  import ldrmp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WK = 8;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ctrl_load, wr_stb, rd_stb, stop_stb;
  logic [7:0] ctrl_byte, wr_data, rd_data_q;
  logic ptr_ack_q, ptr_nack_q, data_ack_q, rd_valid_q;
  ldrmp_alias_t alias_q;
  logic [3:0] led_o_q, led_oe_q;
  logic [9:0] exp_q[$];
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;

  always #50 clk = ~clk;

  ldrmp_master ldrmp_master_inst (.clk(clk), .ctrl_load(ctrl_load),
    .ctrl_byte(ctrl_byte), .wr_stb(wr_stb), .wr_data(wr_data),
    .rd_stb(rd_stb), .stop_stb(stop_stb));
  ldrmp_top #(.WAKE(WK), .CHANNELS(4)) ldrmp_top_inst (.clk(clk),
    .rst(rst), .ctrl_load(ctrl_load), .ctrl_byte(ctrl_byte),
    .wr_stb(wr_stb), .wr_data(wr_data), .rd_stb(rd_stb),
    .stop_stb(stop_stb), .ptr_ack_q(ptr_ack_q), .ptr_nack_q(ptr_nack_q),
    .data_ack_q(data_ack_q), .rd_valid_q(rd_valid_q),
    .rd_data_q(rd_data_q), .alias_q(alias_q), .led_o_q(led_o_q),
    .led_oe_q(led_oe_q));

  task automatic summarize();
    if (exp_q.size() != 0) bad_count++;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk_resp(input string nm, input logic [9:0] e, g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_led(input string nm, input logic [15:0] g, e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // ----------------------------------------------------------------
  // response watcher
  // ----------------------------------------------------------------
  always @(negedge clk) begin
    if (!rst && (ptr_ack_q || ptr_nack_q || rd_valid_q || data_ack_q)) begin
      if (exp_q.size() == 0)
        chk_resp("unexpected", 10'h3FF, 10'h000);
      else if (rd_valid_q)
        chk_resp("rd_data", exp_q.pop_front(), {2'd1, rd_data_q});
      else if (data_ack_q)
        chk_resp("wr_ack", exp_q.pop_front(), {2'd2, 8'h01});
      else
        chk_resp("ptr", exp_q.pop_front(),
          {2'd0, 6'h0, ptr_nack_q, ptr_ack_q});
    end
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // drivers that note expectations
  // ----------------------------------------------------------------
  task automatic sp(input logic [3:0] p);
    exp_q.push_back({2'd0, 6'h0, p > OFF_LAST, p <= OFF_LAST});
    ldrmp_master_inst.ptr(p);
  endtask
  task automatic wr(input logic [7:0] d);
    exp_q.push_back({2'd2, 8'h01});
    ldrmp_master_inst.wr(d);
  endtask
  task automatic rd(input logic [7:0] e);
    exp_q.push_back({2'd1, e});
    ldrmp_master_inst.rd();
  endtask
  task automatic wreg(input logic [3:0] p, input logic [7:0] d);
    sp(p);
    wr(d);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic cnt(input int ch, input int n, output int c);
    c = 0;
    repeat (n) begin
      @(negedge clk);
      if (led_o_q[ch] === 1'b0) c++;
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] tab [13];
    logic [7:0] duty [3];
    logic [3:0] hold;
    int c;
    tab = '{8'h91, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
      8'hFF, 8'h00, 8'h00, 8'hE2, 8'hE4, 8'hE8, 8'hE0};
    void'($urandom(32'h8012));
    duty = '{8'($urandom_range(254, 1)), 8'h00, 8'hFF};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int p = 0; p < 13; p++) begin
      sp(4'(p));
      rd(tab[p]);
    end
    for (int p = 13; p < 16; p++) sp(4'(p));
    idle(3);
    chk_led("led_rst", {8'h0, led_oe_q, led_o_q}, 16'h000F);
    wreg(OFF_MODE_CTRL_FIRST, 8'hFE);
    rd(8'h9E);
    idle(3);
    chk_led("alias_en", {12'h0, alias_q[31:28]}, 16'h000E);
    wreg(OFF_ALIAS1, 8'h55);
    rd(8'h54);
    idle(3);
    chk_led("alias_one", {9'h0, alias_q.alias_one}, 16'h002A);
    wreg(OFF_LEDSEL, 8'h01);
    ldrmp_master_inst.stop();
    idle(50);
    chk_led("sleep_hold", {12'h0, led_o_q}, 16'h000F);
    wreg(OFF_MODE_CTRL_FIRST, 8'h01);
    idle(WK + 4);
    chk_led("wake_on", {8'h0, led_oe_q, led_o_q}, 16'h001E);
    wreg(OFF_LEDSEL, 8'h05);
    idle(5);
    chk_led("stop_wait", {12'h0, led_o_q}, 16'h000E);
    ldrmp_master_inst.stop();
    idle(4);
    chk_led("stop_apply", {12'h0, led_o_q}, 16'h000C);
    wreg(OFF_MODE_CTRL_SECOND, 8'h09);
    wreg(OFF_LEDSEL, 8'h01);
    idle(4);
    chk_led("ack_apply", {12'h0, led_o_q}, 16'h000E);
    wreg(OFF_MODE_CTRL_SECOND, 8'h19);
    idle(4);
    chk_led("invert", {8'h0, led_oe_q, led_o_q}, 16'h00E1);
    wreg(OFF_MODE_CTRL_SECOND, 8'h1D);
    idle(4);
    chk_led("push_pull", {8'h0, led_oe_q, led_o_q}, 16'h00F1);
    wreg(OFF_MODE_CTRL_SECOND, 8'h09);
    wreg(OFF_LEDSEL, 8'h08);
    for (int i = 0; i < 3; i++) begin
      wreg(4'h3, duty[i]);
      idle(4);
      cnt(1, 256 * TICK_CYCLES, c);
      chk_led("duty", 16'(c), 16'(duty[i] * TICK_CYCLES));
    end
    wreg(OFF_GDUTY, 8'h00);
    wreg(OFF_LEDSEL, 8'h0C);
    idle(4);
    cnt(1, 256 * TICK_CYCLES, c);
    chk_led("grp_off", 16'(c), 16'h0000);
    wreg(OFF_LEDSEL, 8'h08);
    wreg(4'h3, 8'h80);
    wreg(OFF_MODE_CTRL_FIRST, 8'h11);
    idle(2);
    hold = led_o_q;
    idle(300);
    chk_led("sleep_freeze", {12'h0, led_o_q}, {12'h0, hold});
    // mid-run reset: group counter restarts from zero, gate known open
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(8'h91);
    wreg(OFF_MODE_CTRL_FIRST, 8'h01);
    wreg(OFF_LEDSEL, 8'h0C);
    wreg(4'h3, 8'h81);
    ldrmp_master_inst.stop();
    idle(WK + 4);
    cnt(1, 64 * TICK_CYCLES, c);
    chk_led("grp_dim", 16'(c), 16'((8'h81 >> 2) * TICK_CYCLES));
    wreg(OFF_MODE_CTRL_SECOND, 8'h21);
    idle(4);
    cnt(1, 256 * TICK_CYCLES, c);
    chk_led("blink", 16'(c), 16'(8'h81 * TICK_CYCLES));
    summarize();
  end
endmodule
